// [design/nsl_defines.vh]
`ifndef NSL_DEFINES_VH
`define NSL_DEFINES_VH

// display mode encoding
`define NSL_MODE_ONE        1'b0
`define NSL_MODE_TWO        1'b1

// clock and blink rates in hertz
`define NSL_CLK_HZ          25000000
`define NSL_ACT_BLINK_HZ    10
`define NSL_COL_BLINK_HZ    20

// half-period counts for the two blink waveforms
`define NSL_ACT_HALF        (`NSL_CLK_HZ / (2 * `NSL_ACT_BLINK_HZ))
`define NSL_COL_HALF        (`NSL_CLK_HZ / (2 * `NSL_COL_BLINK_HZ))

`define NSL_CNT_W           24

// lamp levels
`define NSL_LAMP_OFF        1'b0
`define NSL_LAMP_ON         1'b1

// mode select bit of each output
`define NSL_SEL_LINK        0
`define NSL_SEL_SPEED       1
`define NSL_SEL_DUPLEX      2

// divider lanes
`define NSL_WAVE_ACT        0
`define NSL_WAVE_COL        1

`endif

// [design/nsl_led_driver.v]
`include "nsl_defines.vh"

// Behaviour
// R1: each of three indicator outputs selects display mode one or two independently.
// R2: mode one: link/activity indicator steady on while link is good.
// R3: mode one: link/activity indicator blinks at 10 Hz during valid traffic.
// R4: mode two: link/activity blinks 10 Hz on traffic, regardless of link.
// R5: mode one: speed indicator on at 100 Mb/s, off at 10 Mb/s.
// R6: mode two: speed indicator on while a 100 Mb/s link is up.
// R7: mode one: duplex/collision indicator steady on in full duplex.
// R8: mode one: half duplex collision makes duplex/collision blink at 20 Hz.
// R9: mode two: duplex/collision indicator on while running at 10 Mb/s.
// R10: blinks are divided core clock, about half duty; no trigger means off.
module nsl_led_driver #(
    parameter CNT_W    = `NSL_CNT_W,
    parameter ACT_HALF = `NSL_ACT_HALF,
    parameter COL_HALF = `NSL_COL_HALF
)(
    input  wire       mclk_i,
    input  wire       rst_n_i,
    input  wire [2:0] mode_sel_i,
    input  wire       link_good_i,
    input  wire       speed_100_i,
    input  wire       full_duplex_i,
    input  wire       collision_i,
    input  wire       rx_active_i,
    input  wire       tx_active_i,
    output reg        link_activity_indicator_o,
    output reg        speed_indicator_o,
    output reg        duplex_collision_indicator_o
);

    localparam             NUM_WAVES  = 2;
    localparam             SEL_W      = 3;
    localparam [CNT_W-1:0] CNT_ZERO   = {CNT_W{1'b0}};
    localparam [CNT_W-1:0] CNT_ONE    = {{(CNT_W-1){1'b0}}, 1'b1};
    localparam integer     ACT_LAST_I = ACT_HALF - 1;
    localparam integer     COL_LAST_I = COL_HALF - 1;

    // terminal counts cut to the counter width on purpose
    localparam [CNT_W-1:0] ACT_LAST   = ACT_LAST_I[CNT_W-1:0];
    localparam [CNT_W-1:0] COL_LAST   = COL_LAST_I[CNT_W-1:0];

    wire [NUM_WAVES-1:0] wave;
    wire                 act_wave;
    wire                 col_wave;
    wire                 traffic;
    wire                 link_100;
    wire                 link_10;
    wire                 link_mode_two;
    wire                 speed_mode_two;
    wire                 dup_mode_two;

    reg                  next_link_act;
    reg                  next_speed;
    reg                  next_dup_col;

    // one decoder serves all three outputs so their mode bits stay independent
    function mode_is_two;
        input [SEL_W-1:0] sel;
        input integer     idx;
        begin
            mode_is_two = (sel[idx] == `NSL_MODE_TWO); // R1
        end
    endfunction

    assign traffic        = rx_active_i | tx_active_i;
    assign act_wave       = wave[`NSL_WAVE_ACT];
    assign col_wave       = wave[`NSL_WAVE_COL];
    assign link_100       = link_good_i & speed_100_i;
    assign link_10        = link_good_i & ~speed_100_i;
    assign link_mode_two  = mode_is_two(mode_sel_i, `NSL_SEL_LINK); // R1
    assign speed_mode_two = mode_is_two(mode_sel_i, `NSL_SEL_SPEED); // R1
    assign dup_mode_two   = mode_is_two(mode_sel_i, `NSL_SEL_DUPLEX); // R1

    // free-running dividers: blink phase is not tied to traffic, so no edge glitches
    // lane 0 paces the activity blink, lane 1 the collision blink
    genvar w;
    generate
        for (w = 0; w < NUM_WAVES; w = w + 1)
        begin : g_div
            wire [CNT_W-1:0] last;
            wire             tick;
            reg  [CNT_W-1:0] cnt;
            reg              level;

            assign last = (w == `NSL_WAVE_ACT) ? ACT_LAST : COL_LAST;
            assign tick = (cnt == last);

            always @(posedge mclk_i)
            begin
                if (!rst_n_i)
                begin
                    cnt <= CNT_ZERO;
                end
                else if (tick)
                begin
                    cnt <= CNT_ZERO; // R10
                end
                else
                begin
                    cnt <= cnt + CNT_ONE;
                end
            end

            // tick is a one-cycle enable; toggling on it gives a half duty cycle
            always @(posedge mclk_i)
            begin
                if (!rst_n_i)
                begin
                    level <= `NSL_LAMP_OFF;
                end
                else if (tick)
                begin
                    level <= ~level; // R10
                end
            end

            assign wave[w] = level;
        end
    endgenerate

    // traffic blink outranks the steady link level in mode one
    always @*
    begin
        next_link_act = `NSL_LAMP_OFF; // R10
        if (link_mode_two)
        begin
            if (traffic)
            begin
                next_link_act = act_wave; // R4
            end
        end
        else
        begin
            if (traffic)
            begin
                next_link_act = act_wave; // R3
            end
            else
            begin
                next_link_act = link_good_i; // R2
            end
        end
    end

    // mode one follows speed alone; link state is not consulted
    always @*
    begin
        next_speed = `NSL_LAMP_OFF;
        if (speed_mode_two)
        begin
            next_speed = link_100; // R6
        end
        else
        begin
            next_speed = speed_100_i; // R5
        end
    end

    // full duplex wins over collision; quiet half duplex stays dark
    always @*
    begin
        next_dup_col = `NSL_LAMP_OFF; // R10
        if (dup_mode_two)
        begin
            next_dup_col = link_10; // R9
        end
        else
        begin
            if (full_duplex_i)
            begin
                next_dup_col = `NSL_LAMP_ON; // R7
            end
            else
            begin
                if (collision_i)
                begin
                    next_dup_col = col_wave; // R8
                end
            end
        end
    end

    // registered so lamp pins never show decode glitches; dark through reset
    always @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            link_activity_indicator_o <= `NSL_LAMP_OFF;
        end
        else
        begin
            link_activity_indicator_o <= next_link_act;
        end
    end

    always @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            speed_indicator_o <= `NSL_LAMP_OFF;
        end
        else
        begin
            speed_indicator_o <= next_speed;
        end
    end

    always @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            duplex_collision_indicator_o <= `NSL_LAMP_OFF;
        end
        else
        begin
            duplex_collision_indicator_o <= next_dup_col;
        end
    end

endmodule // nsl_led_driver

// [sim/nsl_lamp.sv]
module nsl_lamp (
    input wire mclk_i,
    input wire lamp_i
);
    timeunit 1ns; timeprecision 1ns;
    // a lamp shows only its level; counting changes exposes the blink rate
    logic last = 1'b0;
    int   flips = 0;
    always @(posedge mclk_i)
    begin
        flips <= flips + (lamp_i != last);
        last  <= lamp_i;
    end
endmodule // nsl_lamp

// [sim/nsl_led_driver_assertions.sv]
module nsl_led_chk #(
    parameter ACT_HALF = 1250000,
    parameter COL_HALF = 625000
)(
    input wire       mclk_i,
    input wire       rst_n_i,
    input wire [2:0] mode_sel_i,
    input wire       link_good_i,
    input wire       speed_100_i,
    input wire       full_duplex_i,
    input wire       collision_i,
    input wire       rx_active_i,
    input wire       tx_active_i,
    input wire       link_activity_indicator_o,
    input wire       speed_indicator_o,
    input wire       duplex_collision_indicator_o
);
    timeunit 1ns; timeprecision 1ns;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    wire [2:0] m = mode_sel_i;
    wire       g = link_good_i, s = speed_100_i, f = full_duplex_i, c = collision_i;
    wire       t = rx_active_i | tx_active_i, l = link_activity_indicator_o;
    wire       p = speed_indicator_o, d = duplex_collision_indicator_o;
    // first edge after release still shows reset zeros, so mask it
    reg        v = 1'b0;
    // run lengths: how long a lamp held its level and how long its blink cause stood
    reg        l_q = 1'b0, d_q = 1'b0;
    int        l_age = 0, d_age = 0, t_age = 0, c_age = 0;
    always @(posedge mclk_i)
    begin
        v     <= rst_n_i;
        l_q   <= l;
        d_q   <= d;
        l_age <= (l != l_q) ? 1 : l_age + 1;
        d_age <= (d != d_q) ? 1 : d_age + 1;
        t_age <= (rst_n_i && t) ? t_age + 1 : 0;
        c_age <= (rst_n_i && !m[2] && !f && c) ? c_age + 1 : 0;
    end
    chk_link_on: assert property (v && $past(!m[0] && g && !t) |-> l) else $error("bad");
    chk_act_off: assert property (v && $past(m[0] && !t) |-> !l) else $error("bad");
    chk_act_blink: assert property (
        t_age > 2 * ACT_HALF + 2 |-> l_age <= ACT_HALF && (!$changed(l) || l_age == ACT_HALF))
        else $error("bad");
    chk_spd_one: assert property (v && $past(!m[1]) |-> p == $past(s)) else $error("bad");
    chk_spd_two: assert property (v && $past(m[1]) |-> p == $past(g & s)) else $error("bad");
    chk_dc_full: assert property (v && $past(!m[2] && f) |-> d) else $error("bad");
    chk_dc_col: assert property (
        c_age > 2 * COL_HALF + 2 |-> d_age <= COL_HALF && (!$changed(d) || d_age == COL_HALF))
        else $error("bad");
    chk_dc_ten: assert property (v && $past(m[2]) |-> d == $past(g & !s)) else $error("bad");
    chk_dc_dark: assert property (v && $past(!m[2] && !f && !c) |-> !d) else $error("bad");
endmodule // nsl_led_chk

bind nsl_led_driver nsl_led_chk #(
    .ACT_HALF (ACT_HALF),
    .COL_HALF (COL_HALF)
) chk (
    .mclk_i                       (mclk_i),
    .rst_n_i                      (rst_n_i),
    .mode_sel_i                   (mode_sel_i),
    .link_good_i                  (link_good_i),
    .speed_100_i                  (speed_100_i),
    .full_duplex_i                (full_duplex_i),
    .collision_i                  (collision_i),
    .rx_active_i                  (rx_active_i),
    .tx_active_i                  (tx_active_i),
    .link_activity_indicator_o    (link_activity_indicator_o),
    .speed_indicator_o            (speed_indicator_o),
    .duplex_collision_indicator_o (duplex_collision_indicator_o)
);

// [sim/tb_network_status_led_driver.sv]
module tb_network_status_led_driver;
    timeunit 1ns; timeprecision 1ns;
    logic       clk = 1'b0, rst_n = 1'b0, g = 1'b0, s = 1'b0, f = 1'b0, c = 1'b0, rx = 1'b0;
    logic       tx = 1'b0;
    logic [2:0] m = 3'h0;
    wire        la, sp, dc;
    int         errors = 0, num_checks = 0;
    always #20 clk = ~clk;
    nsl_led_driver #(.ACT_HALF(4), .COL_HALF(2)) uut (.mclk_i(clk), .rst_n_i(rst_n), .mode_sel_i(m),
        .link_good_i(g), .speed_100_i(s), .full_duplex_i(f), .collision_i(c), .rx_active_i(rx),
        .tx_active_i(tx), .link_activity_indicator_o(la), .speed_indicator_o(sp),
        .duplex_collision_indicator_o(dc));
    nsl_lamp lamp_la (.mclk_i(clk), .lamp_i(la));
    nsl_lamp lamp_dc (.mclk_i(clk), .lamp_i(dc));
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %0t %h %h", $time, got, exp);
        end
    endtask
    task t_levels;
        logic [2:0] e;
        for (int i = 0; i < 128; i++)
        begin
            {m, g, s, f, c} = i[6:0];
            cyc(2);
            e = {!m[0] && g, m[1] ? g && s : s, m[2] ? g && !s : f};
            if (m[2] || f || !c)
                chk({5'h0, la, sp, dc}, {5'h0, e});
        end
    endtask
    task t_blink;
        int a, d;
        for (int j = 0; j < 2; j++)
        begin
            m = {3{j[0]}};
            {g, s, f, c, rx, tx} = {4'h9, !j[0], j[0]};
            cyc(8);
            a = lamp_la.flips;
            d = lamp_dc.flips;
            cyc(80);
            chk(8'(lamp_la.flips - a), 8'h14);
            chk(8'(lamp_dc.flips - d), j ? 8'h00 : 8'h28);
        end
    endtask
    task end_sim;
        $display("errors %0d checks %0d", errors, num_checks);
        if (errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        cyc(10);
        rst_n = 1'b1;
        t_levels;
        t_blink;
        end_sim;
    end
endmodule // tb_network_status_led_driver
